//--- dv/sfid_core_asserts.sv
// concurrent checks on the sequencer status and lane enables
`timescale 1ns/1ps
module sfid_core_asserts
  import sfid_pkg::*;
#(
  parameter int BLOCK_WIPE_CYC = 20,
  parameter int FULL_WIPE_CYC  = 40
) (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  // link
  input wire logic       cs_n_i,
  input wire logic [3:0] io_oe_o,
  // protection
  input wire logic       protect_level_b0_i,
  input wire logic       protect_level_b1_i,
  input wire logic       protect_level_b2_i,
  input wire logic       protect_invert_i,
  // status
  input wire logic       busy_flag_o,
  input wire logic       write_latch_o,
  input wire logic       deep_sleep_o,
  input wire logic       wipe_chip_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  int unsigned busy_cnt_r;
  int unsigned cs_hi_r;
  logic        chip_r;
  // cycles of the running wipe and its kind
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt_r <= 0;
      chip_r     <= 1'b0;
    end else begin
      busy_cnt_r <= busy_flag_o ? busy_cnt_r + 1 : 0;
      if (busy_flag_o) chip_r <= wipe_chip_o;
    end
  end
  // cycles with select high, saturating
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) cs_hi_r <= 0;
    else cs_hi_r <= cs_n_i ? ((cs_hi_r < 1000) ? cs_hi_r + 1 : cs_hi_r) : 0;
  end
  wipe_length_a: assert property (
    $fell(busy_flag_o) |-> busy_cnt_r == (chip_r ? FULL_WIPE_CYC : BLOCK_WIPE_CYC))
    else $error("wipe length wrong");
  latch_cleared_a: assert property (
    $fell(busy_flag_o) |-> !write_latch_o) else $error("latch set at wipe end");
  wipe_needs_latch_a: assert property (
    $rose(busy_flag_o) |-> write_latch_o) else $error("wipe without latch");
  no_wipe_asleep_a: assert property (
    $rose(busy_flag_o) |-> !$past(deep_sleep_o)) else $error("wipe while asleep");
  sleep_not_busy_a: assert property (
    busy_flag_o |-> !deep_sleep_o) else $error("asleep during wipe");
  sleep_delay_a: assert property (
    $rose(deep_sleep_o) |-> cs_hi_r >= SLEEP_ENTRY_CYC) else $error("sleep entered early");
  reset_standby_a: assert property (
    $rose(resetn_i) |-> !deep_sleep_o && !busy_flag_o) else $error("not standby after reset");
  lane_set_a: assert property (
    io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad lane enable set");
  oe_deselect_a: assert property (
    cs_n_i |-> io_oe_o == 4'h0) else $error("lanes driven while deselected");
  chip_guard_a: assert property (
    $rose(wipe_chip_o) |-> {protect_invert_i, protect_level_b2_i, protect_level_b1_i, protect_level_b0_i}
      inside {4'h0, 4'hD, 4'hE, 4'hF}) else $error("full wipe while protected");
  cover property ($fell(busy_flag_o) && chip_r);
  cover property ($fell(busy_flag_o) && !chip_r);
  cover property ($rose(deep_sleep_o));
  cover property (io_oe_o == 4'hF);
endmodule // sfid_core_asserts

bind sfid_core sfid_core_asserts #(.BLOCK_WIPE_CYC(BLOCK_WIPE_CYC), .FULL_WIPE_CYC(FULL_WIPE_CYC)) u_chk (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o),
  .protect_level_b0_i(protect_level_b0_i), .protect_level_b1_i(protect_level_b1_i),
  .protect_level_b2_i(protect_level_b2_i), .protect_invert_i(protect_invert_i),
  .busy_flag_o(busy_flag_o), .write_latch_o(write_latch_o), .deep_sleep_o(deep_sleep_o),
  .wipe_chip_o(wipe_chip_o));

//--- dv/sfid_core_tb.sv
// self-checking bench for the wipe, sleep and ident sequencer
`timescale 1ns/1ps
module sfid_core_tb;
  import sfid_pkg::*;
  localparam int         BWC    = 400;
  localparam int         FWC    = 600;
  localparam logic [7:0] MK     = 8'h5A;  // arbitrary value
  localparam logic [7:0] PT     = 8'h13;  // arbitrary value
  localparam logic [7:0] MT     = 8'h40;  // arbitrary value
  localparam logic [7:0] CP     = 8'h14;  // arbitrary value
  localparam logic [7:0] OPS[8] = '{OP_IDENT_TRIPLET, OP_MAKER_PART, OP_MAKER_PART, OP_MAKER_PART_DUAL,
                                    OP_MAKER_PART_DUAL, OP_MAKER_PART_QUAD, OP_MAKER_PART_QUAD, OP_WAKE_IDENT};
  localparam logic [3:0] PC[7]  = '{4'h0, 4'h1, 4'hD, 4'hE, 4'hF, 4'h8, 4'h5};
  logic        mclk_i   = 1'b0;
  logic        resetn_i = 1'b0;
  int          oe_cnt   = 0;
  logic        sclk, cs_n, busy, latch, sleep, chip;
  logic [3:0]  hio, dio, doe, io_w;
  logic [7:0]  blk;
  logic [5:0]  prot = 6'h00;  // invert, b4, b3, b2, b1, b0
  logic [47:0] rd;
  logic [23:0] a;
  int          w, seed, n0;
  int          fail_count = 0;
  int          total_checks = 0;
  always #10 mclk_i = ~mclk_i;
  // wire level: device where enabled, host elsewhere
  assign io_w = (doe & dio) | (~doe & hio);
  // notes any lane the device drives
  always @(posedge mclk_i) if (doe !== 4'h0) oe_cnt <= oe_cnt + 1;
  sfid_core #(.BLOCK_WIPE_CYC(BWC), .FULL_WIPE_CYC(FWC), .MAKER_ID(MK), .PART_ID(PT), .MEM_TYPE_ID(MT),
              .CAPACITY_ID(CP)) DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .link_sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_w), .io_o(dio),
    .io_oe_o(doe), .protect_level_b0_i(prot[0]), .protect_level_b1_i(prot[1]), .protect_level_b2_i(prot[2]),
    .protect_level_b3_i(prot[3]), .protect_level_b4_i(prot[4]), .protect_invert_i(prot[5]),
    .busy_flag_o(busy), .write_latch_o(latch), .deep_sleep_o(sleep), .wipe_chip_o(chip), .wipe_block_o(blk));
  sfid_host u_host (.mclk_i(mclk_i), .io_i(io_w), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(hio));
  // expected repeating ident stream
  function automatic logic [47:0] id_exp(input logic [7:0] op, input logic [23:0] ad);
    if (op == OP_IDENT_TRIPLET) return {2{MK, MT, CP}};
    if (op == OP_WAKE_IDENT) return {6{PT}};
    return (ad == ADDR_ID_SWAP) ? {3{PT, MK}} : {3{MK, PT}};
  endfunction
  // whole-array wipe allowed for {invert, level}
  function automatic logic chip_ok(input logic [3:0] p);
    return (p == 4'h0) || (p[3] && (p[2:0] == 3'h5 || p[2:1] == 2'h3));
  endfunction
  function automatic int lanes(input logic [7:0] op);
    return (op == OP_MAKER_PART_DUAL) ? 2 : (op == OP_MAKER_PART_QUAD) ? 4 : 1;
  endfunction
  task automatic chk_data(input string n, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic chk_flag(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait on busy (k 0) or sleep (k 1)
  task automatic wait_for(input int k, input logic v, input int lim);
    for (int n = 0; n < lim && (k == 0 ? busy : sleep) !== v; n++) @(posedge mclk_i);
    chk_flag("wait", v, k == 0 ? busy : sleep);
    if ((k == 0 ? busy : sleep) !== v) stop_test();
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] ad, input int nin);
    u_host.frame(op, ad, nin, 1, 0, rd);
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic set_prot(input logic [5:0] p);
    @(posedge mclk_i) prot <= p;
    repeat (4) @(posedge mclk_i);
  endtask
  initial begin
    seed = $urandom(51258);
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk_flag("sleep", 1'b0, sleep);
    // ident reads over one, two and four lanes
    for (int k = 0; k < 8; k++) begin
      w = lanes(OPS[k]);
      a = (k == 7) ? 24'($urandom) : ((k % 2 == 0) ? ADDR_ID_SWAP : 24'h000000);
      u_host.frame(OPS[k], a, (k == 0) ? 0 : 24 / w, w, 48 / w, rd);
      chk_data("ident", id_exp(OPS[k], a), rd);
    end
    u_host.frame(OP_IDENT_TRIPLET, 24'h000000, 0, 1, 5, rd);
    chk_data("short ident", 48'(MK[7:3]), rd);
    chk_flag("lanes off", 1'b1, doe === 4'h0);
    // block wipe at a random address, commands during it
    a = 24'($urandom);
    cmd(OP_WRITE_UNLOCK, 24'h000000, 0);
    chk_flag("latch", 1'b1, latch);
    cmd(OP_BLOCK_WIPE, a, 24);
    wait_for(0, 1'b1, 10);
    chk_data("block", 48'(a[23:16]), 48'(blk));
    chk_flag("block not whole", 1'b0, chip);
    n0 = oe_cnt;
    u_host.frame(OP_IDENT_TRIPLET, 24'h000000, 0, 1, 8, rd);
    chk_flag("ident busy", 1'b0, oe_cnt != n0);
    cmd(OP_SLEEP, 24'h000000, 0);
    chk_flag("busy", 1'b1, busy);
    wait_for(0, 1'b0, BWC);
    chk_flag("latch", 1'b0, latch);
    repeat (SLEEP_ENTRY_CYC + 10) @(posedge mclk_i);
    chk_flag("sleep", 1'b0, sleep);
    // wipes that must not start
    cmd(OP_WRITE_UNLOCK, 24'h000000, 0);
    cmd(OP_BLOCK_WIPE, a, 23);
    chk_flag("short wipe", 1'b0, busy);
    w = $urandom % 2;
    set_prot({2'h0, w[0], 3'h1});
    cmd(OP_BLOCK_WIPE, {4'($urandom), w[0] ? 4'h0 : 4'hF, 16'($urandom)}, 24);
    repeat (20) @(posedge mclk_i);
    chk_flag("guarded wipe", 1'b0, busy);
    chk_flag("latch kept", 1'b1, latch);
    // whole-array wipe across protect settings
    for (int k = 0; k < 7; k++) begin
      set_prot({PC[k][3], 2'h0, PC[k][2:0]});
      cmd(OP_WRITE_UNLOCK, 24'h000000, 0);
      cmd((k % 2) ? OP_FULL_WIPE_B : OP_FULL_WIPE_A, 24'h000000, 0);
      chk_flag("full wipe", chip_ok(PC[k]), busy);
      if (busy === 1'b1) begin
        chk_flag("whole array", 1'b1, chip);
        n0 = oe_cnt;
        if (k == 0) u_host.frame(OP_WAKE_IDENT, 24'h000000, 24, 1, 8, rd);
        chk_flag("wake busy", 1'b0, oe_cnt != n0);
        wait_for(0, 1'b0, FWC);
      end
    end
    set_prot(6'h00);
    cmd(OP_WRITE_UNLOCK, 24'h000000, 0);
    cmd(OP_FULL_WIPE_B, 24'h000000, 1);
    chk_flag("long full wipe", 1'b0, busy);
    // sleep entry, refusals while asleep, both wakes
    cmd(OP_SLEEP, 24'h000000, 1);
    repeat (SLEEP_ENTRY_CYC + 10) @(posedge mclk_i);
    chk_flag("long sleep", 1'b0, sleep);
    cmd(OP_SLEEP, 24'h000000, 0);
    wait_for(1, 1'b1, SLEEP_ENTRY_CYC + 10);
    n0 = oe_cnt;
    u_host.frame(OP_MAKER_PART, 24'h000000, 24, 1, 16, rd);
    cmd(OP_BLOCK_WIPE, a, 24);
    chk_flag("asleep lanes", 1'b0, oe_cnt != n0);
    chk_flag("asleep wipe", 1'b0, busy);
    cmd(OP_WAKE_IDENT, 24'h000000, 0);
    chk_flag("awake", 1'b0, sleep);
    cmd(OP_FULL_WIPE_A, 24'h000000, 0);
    chk_flag("wake delay", 1'b0, busy);
    repeat (WAKE_PLAIN_CYC) @(posedge mclk_i);
    cmd(OP_SLEEP, 24'h000000, 0);
    wait_for(1, 1'b1, SLEEP_ENTRY_CYC + 10);
    u_host.frame(OP_WAKE_IDENT, 24'h000000, 24, 1, 8, rd);
    chk_data("wake ident", 48'(PT), rd);
    chk_flag("awake", 1'b0, sleep);
    n0 = oe_cnt;
    u_host.frame(OP_IDENT_TRIPLET, 24'h000000, 0, 1, 8, rd);
    chk_flag("ident delay", 1'b0, oe_cnt != n0);
    stop_test();
  end
endmodule // sfid_core_tb

//--- dv/sfid_host.sv
// host controller model: select, serial clock and lanes
`timescale 1ns/1ps
module sfid_host (
  // frame starts follow this clock
  input  wire logic       mclk_i,
  // lane levels on the wire
  input  wire logic [3:0] io_i,
  // link outputs
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic      [3:0] io_o
);
  // link idles with clock low and select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o   = 4'h0;
  end
  // opcode, nin address cycles on w lanes, then nrd read cycles
  task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int nin, input int w,
                       input int nrd, output logic [47:0] rd);
    logic [31:0] sh;
    int          lw;
    sh = {op, adr};
    rd = '0;
    @(posedge mclk_i);
    #3 cs_n_o = 1'b0;
    #100;
    for (int i = 0; i < 8 + nin; i++) begin
      lw = (i < 8) ? 1 : w;
      io_o = 4'(sh[31:28] >> (4 - lw));
      sh = sh << lw;
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    for (int i = 0; i < nrd; i++) begin
      io_o = ~io_o;  // released lanes keep changing
      #62.5 rd = (rd << w) | 48'((w == 1) ? {3'h0, io_i[1]} : (w == 2) ? {2'h0, io_i[1:0]} : io_i);
      sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    #62.5 cs_n_o = 1'b1;
    #100;
  endtask
endmodule // sfid_host

//--- rtl/sfid_core.sv
// serial flash sequencer: erase, deep sleep, wake and identification commands
`timescale 1ns/1ps

module sfid_core
  import sfid_pkg::*;
#(
  parameter int          NUM_BLOCKS     = 16,
  parameter int          BLOCK_WIPE_CYC = BLOCK_WIPE_DURATION_US * CLK_MHZ,
  parameter int          FULL_WIPE_CYC  = FULL_WIPE_DURATION_MS * 1000 * CLK_MHZ,
  parameter logic [7:0]  MAKER_ID       = 8'h5A,  // arbitrary value
  parameter logic [7:0]  PART_ID        = 8'h13,  // arbitrary value
  parameter logic [7:0]  MEM_TYPE_ID    = 8'h40,  // arbitrary value
  parameter logic [7:0]  CAPACITY_ID    = 8'h14   // arbitrary value
) (
  // system clock and reset
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // serial link from the host
  input  wire logic       link_sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_o,
  // protection settings
  input  wire logic       protect_level_b0_i,
  input  wire logic       protect_level_b1_i,
  input  wire logic       protect_level_b2_i,
  input  wire logic       protect_level_b3_i,
  input  wire logic       protect_level_b4_i,
  input  wire logic       protect_invert_i,
  // status
  output logic            busy_flag_o,
  output logic            write_latch_o,
  output logic            deep_sleep_o,
  output logic            wipe_chip_o,
  output logic      [7:0] wipe_block_o
);

  // refuse settings the logic cannot serve: block index is 8 bits, wipes need a cycle
  if (NUM_BLOCKS < 1 || NUM_BLOCKS > 256 || BLOCK_WIPE_CYC < 1 || FULL_WIPE_CYC < 1) begin : g_bad_params
    $error("sfid_core: NUM_BLOCKS must be 1..256 and wipe durations at least one cycle");
  end

  // lanes used after the opcode: 1, 2 or 4
  function automatic logic [2:0] lanes(input logic [7:0] op);
    return (op == OP_MAKER_PART_DUAL) ? 3'h2 : (op == OP_MAKER_PART_QUAD) ? 3'h4 : 3'h1;
  endfunction

  // true for the commands that answer with identification bytes
  function automatic logic is_ident(input logic [7:0] op);
    return (op == OP_WAKE_IDENT) || (op == OP_MAKER_PART) || (op == OP_MAKER_PART_DUAL) ||
           (op == OP_MAKER_PART_QUAD) || (op == OP_IDENT_TRIPLET);
  endfunction

  // sequencer state and status, declared first: the link side reads the status levels
  sfid_state_t state_r, state_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic        cs_s1_r, cs_s2_r, tog_s1_r, tog_s2_r, tog_seen_r, frame_done;
  logic [5:0]  prot_s1_r, prot_s2_r;
  logic        busy_flag_r, write_latch_r, deep_sleep_r, sleep_r, wake_r, wipe_chip_r;
  logic [7:0]  wipe_block_r;
  logic        set_latch, clr_latch, start_block, start_chip;

  // link domain: framing, shift-in and ident output
  logic        lk_rst_n, frame_tog_r, id_allowed, id_show;
  logic [5:0]  cnt_r, cnt_nxt, last_cnt_r, id_start;
  logic [6:0]  cnt_sum;
  logic [2:0]  lane_w, lk_flags_s1_r, lk_flags_s2_r;
  logic [7:0]  op_r;
  logic [23:0] addr_r, id_word;
  logic [4:0]  obit_r, obit_sum, id_period;
  logic [3:0]  io_out_r, io_oe_r, io_bits, io_mask;

  // frame logic is held clear while select is high
  assign lk_rst_n = resetn_i & ~cs_n_i;
  assign lane_w   = lanes(op_r);

  // bit count of this frame, saturating
  always_comb begin
    cnt_sum = {1'b0, cnt_r} + ((cnt_r < LEN_OPCODE) ? 7'h01 : {4'h0, lane_w});
    cnt_nxt = (cnt_sum > {1'b0, LEN_SAT}) ? LEN_SAT : cnt_sum[5:0];
  end

  always_ff @(posedge link_sclk_i or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // opcode and address shift in MSB first on rising edges
  always_ff @(posedge link_sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_r   <= 8'h00;
      addr_r <= 24'h000000;
    end else if (cs_n_i == 1'b0) begin
      if (cnt_r < LEN_OPCODE) begin
        op_r <= {op_r[6:0], io_i[0]};
      end else if (cnt_r < LEN_OPADDR) begin
        unique case (lane_w)
          3'h2:    addr_r <= {addr_r[21:0], io_i[1], io_i[0]};
          3'h4:    addr_r <= {addr_r[19:0], io_i[3:0]};
          default: addr_r <= {addr_r[22:0], io_i[0]};
        endcase
      end
    end
  end

  // frame length kept past deselect; toggle marks a frame with clocks in it
  always_ff @(posedge link_sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_cnt_r  <= 6'h00;
      frame_tog_r <= 1'b0;
    end else if (cs_n_i == 1'b0) begin
      last_cnt_r <= cnt_nxt;
      if (cnt_r == 6'h00) begin
        frame_tog_r <= ~frame_tog_r;
      end
    end
  end

  // sequencer levels brought onto the link clock
  always_ff @(posedge link_sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lk_flags_s1_r <= 3'h0;
      lk_flags_s2_r <= 3'h0;
    end else begin
      lk_flags_s1_r <= {wake_r, sleep_r, busy_flag_r};
      lk_flags_s2_r <= lk_flags_s1_r;
    end
  end

  // identification word, its length and where output begins
  always_comb begin
    id_word   = {MAKER_ID, MEM_TYPE_ID, CAPACITY_ID};
    id_period = 5'h18;
    id_start  = LEN_OPCODE;
    if (op_r == OP_WAKE_IDENT) begin
      id_word   = {PART_ID, 16'h0000};
      id_period = 5'h08;
      id_start  = LEN_OPADDR;
    end else if (op_r != OP_IDENT_TRIPLET) begin
      id_word   = (addr_r == ADDR_ID_SWAP) ? {PART_ID, MAKER_ID, 8'h00} : {MAKER_ID, PART_ID, 8'h00};
      id_period = 5'h10;
      id_start  = LEN_OPADDR;
    end
  end

  // who may answer: flags are {wake, sleep, busy}
  always_comb begin
    if (lk_flags_s2_r[2]) begin
      id_allowed = 1'b0;
    end else if (op_r == OP_WAKE_IDENT) begin
      id_allowed = ~lk_flags_s2_r[0];
    end else if (lk_flags_s2_r[1]) begin
      id_allowed = 1'b0;
    end else begin
      id_allowed = ~(op_r == OP_IDENT_TRIPLET && lk_flags_s2_r[0]);
    end
    id_show = is_ident(op_r) && (cnt_r >= id_start) && id_allowed;
  end

  // output bits for the lanes at the current word position
  always_comb begin
    io_bits = 4'h0;
    io_mask = 4'h2;
    if (lane_w == 3'h1) begin
      io_bits[1] = id_word[5'h17 - obit_r];
    end else begin
      for (int j = 0; j < 4; j++) begin
        if (j < int'(lane_w)) begin
          io_bits[int'(lane_w) - 1 - j] = id_word[5'h17 - obit_r - 5'(j)];
        end
      end
      io_mask = (lane_w == 3'h2) ? 4'h3 : 4'hF;
    end
    obit_sum = obit_r + {2'h0, lane_w};
  end

  // drive on falling edges; select high drops the lanes at once
  always_ff @(negedge link_sclk_i or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      obit_r   <= 5'h00;
      io_out_r <= 4'h0;
      io_oe_r  <= 4'h0;
    end else if (id_show) begin
      io_out_r <= io_bits;
      io_oe_r  <= io_mask;
      obit_r   <= (obit_sum >= id_period) ? 5'h00 : obit_sum;
    end else begin
      io_out_r <= 4'h0;
      io_oe_r  <= 4'h0;
    end
  end

  assign io_o    = io_out_r;
  assign io_oe_o = io_oe_r;

  // system domain: sequencer, write latch and status

  // select, frame toggle and protect pins through two flops
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      tog_s1_r  <= 1'b0;
      tog_s2_r  <= 1'b0;
      prot_s1_r <= 6'h00;
      prot_s2_r <= 6'h00;
    end else begin
      cs_s1_r   <= cs_n_i;
      cs_s2_r   <= cs_s1_r;
      tog_s1_r  <= frame_tog_r;
      tog_s2_r  <= tog_s1_r;
      prot_s1_r <= {protect_invert_i, protect_level_b4_i, protect_level_b3_i,
                    protect_level_b2_i, protect_level_b1_i, protect_level_b0_i};
      prot_s2_r <= prot_s1_r;
    end
  end

  // a frame ends when select is back high after a clocked frame
  assign frame_done = cs_s2_r && (tog_s2_r != tog_seen_r);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tog_seen_r <= 1'b0;
    end else if (frame_done) begin
      tog_seen_r <= tog_s2_r;
    end
  end

  // protection of one 64KB block
  function automatic logic blk_protected(input logic [7:0] blk, input logic [5:0] prot);
    int n, b;
    b = int'(blk) % NUM_BLOCKS;
    if (prot[PROT_LEVEL_LSB +: 3] == 3'h0) begin
      n = 0;
    end else if (prot[PROT_SECTOR_BIT]) begin
      n = 1;
    end else begin
      n = 1 << (int'(prot[PROT_LEVEL_LSB +: 3]) - 1);
    end
    if (n > NUM_BLOCKS) begin
      n = NUM_BLOCKS;
    end
    return (prot[PROT_SIDE_BIT] ? (b < n) : (b >= NUM_BLOCKS - n)) ^ prot[5];
  endfunction

  // whole-array wipe allowed at level 0, or inverted at level 5 to 7, whatever the sector bit
  function automatic logic chip_open(input logic [5:0] prot);
    logic [2:0] lvl;
    lvl = prot[PROT_LEVEL_LSB +: 3];
    return (!prot[5] && lvl == 3'h0) || (prot[5] && (lvl == 3'h5 || lvl[2:1] == 2'h3));
  endfunction

  // command decode at frame end and the self-timed states
  always_comb begin
    state_nxt   = state_r;
    timer_nxt   = (timer_r != 32'h0) ? timer_r - 32'h1 : 32'h0;
    set_latch   = 1'b0;
    start_block = 1'b0;
    start_chip  = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (frame_done) begin
          if (op_r == OP_WRITE_UNLOCK && last_cnt_r == LEN_OPCODE) begin
            set_latch = 1'b1;
          end else if (op_r == OP_BLOCK_WIPE && last_cnt_r == LEN_OPADDR && write_latch_r &&
                       !blk_protected(addr_r[23:16], prot_s2_r)) begin
            start_block = 1'b1;
            state_nxt   = ST_WIPE;
            timer_nxt   = 32'(BLOCK_WIPE_CYC);
          end else if ((op_r == OP_FULL_WIPE_A || op_r == OP_FULL_WIPE_B) && last_cnt_r == LEN_OPCODE &&
                       write_latch_r && chip_open(prot_s2_r)) begin
            start_chip = 1'b1;
            state_nxt  = ST_WIPE;
            timer_nxt  = 32'(FULL_WIPE_CYC);
          end else if (op_r == OP_SLEEP && last_cnt_r == LEN_OPCODE) begin
            state_nxt = ST_SLEEP_ENTRY;
            timer_nxt = 32'(SLEEP_ENTRY_CYC);
          end
        end
      end
      ST_WIPE: begin
        if (timer_r <= 32'h1) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SLEEP_ENTRY,
      ST_SLEEP: begin
        if (frame_done && op_r == OP_WAKE_IDENT && last_cnt_r >= LEN_OPCODE) begin
          state_nxt = ST_WAKE;
          timer_nxt = (last_cnt_r == LEN_OPCODE) ? 32'(WAKE_PLAIN_CYC) : 32'(WAKE_IDENT_CYC);
        end else if (state_r == ST_SLEEP_ENTRY && timer_r <= 32'h1) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_WAKE: begin
        if (timer_r <= 32'h1) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // latch drops one cycle before busy falls
  assign clr_latch = (state_r == ST_WIPE) && (timer_r <= 32'h2);

  // state and delay counter; reset lands in standby
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
      timer_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
    end
  end

  // write latch: a set wins over a clear
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      write_latch_r <= RST_WRITE_LATCH;
    end else if (set_latch) begin
      write_latch_r <= 1'b1;
    end else if (clr_latch) begin
      write_latch_r <= 1'b0;
    end
  end

  // status levels, also fed to the link side
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_flag_r  <= RST_BUSY_FLAG;
      deep_sleep_r <= RST_DEEP_SLEEP;
      sleep_r      <= 1'b0;
      wake_r       <= 1'b0;
    end else begin
      busy_flag_r  <= (state_nxt == ST_WIPE);
      deep_sleep_r <= (state_nxt == ST_SLEEP);
      sleep_r      <= (state_nxt == ST_SLEEP_ENTRY) || (state_nxt == ST_SLEEP);
      wake_r       <= (state_nxt == ST_WAKE);
    end
  end

  // which area the running wipe covers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wipe_chip_r  <= 1'b0;
      wipe_block_r <= 8'h00;
    end else if (start_block) begin
      wipe_chip_r  <= 1'b0;
      wipe_block_r <= addr_r[23:16];
    end else if (start_chip) begin
      wipe_chip_r  <= 1'b1;
      wipe_block_r <= 8'h00;
    end else if (state_nxt != ST_WIPE) begin
      wipe_chip_r  <= 1'b0;
    end
  end

  assign busy_flag_o   = busy_flag_r;
  assign write_latch_o = write_latch_r;
  assign deep_sleep_o  = deep_sleep_r;
  assign wipe_chip_o   = wipe_chip_r;
  assign wipe_block_o  = wipe_block_r;

endmodule // sfid_core

//--- rtl/sfid_pkg.sv
// shared constants and types for the serial flash erase, sleep and ident sequencer
package sfid_pkg;

  // opcodes taken in during the first byte of a frame
  localparam logic [7:0] OP_WRITE_UNLOCK     = 8'h06;
  localparam logic [7:0] OP_BLOCK_WIPE       = 8'hD8;
  localparam logic [7:0] OP_FULL_WIPE_A      = 8'h60;
  localparam logic [7:0] OP_FULL_WIPE_B      = 8'hC7;
  localparam logic [7:0] OP_SLEEP            = 8'hB9;
  localparam logic [7:0] OP_WAKE_IDENT       = 8'hAB;
  localparam logic [7:0] OP_MAKER_PART       = 8'h90;
  localparam logic [7:0] OP_MAKER_PART_DUAL  = 8'h92;
  localparam logic [7:0] OP_MAKER_PART_QUAD  = 8'h94;
  localparam logic [7:0] OP_IDENT_TRIPLET    = 8'h9F;

  // frame lengths in bits, counted at the link
  localparam logic [5:0] LEN_OPCODE          = 6'h08;
  localparam logic [5:0] LEN_OPADDR          = 6'h20;
  localparam logic [5:0] LEN_SAT             = 6'h3F;

  // address that swaps the maker/part byte order
  localparam logic [23:0] ADDR_ID_SWAP       = 24'h000001;

  // block-protect field positions
  localparam int PROT_LEVEL_LSB              = 0;
  localparam int PROT_SIDE_BIT               = 3;
  localparam int PROT_SECTOR_BIT             = 4;

  // reset values of the status flags
  localparam logic RST_BUSY_FLAG             = 1'b0;
  localparam logic RST_WRITE_LATCH           = 1'b0;
  localparam logic RST_DEEP_SLEEP            = 1'b0;

  // timing, in the units printed, and the clock rate
  localparam int CLK_MHZ                     = 50;
  localparam int BLOCK_WIPE_DURATION_US      = 150000;
  localparam int FULL_WIPE_DURATION_MS       = 8000;
  localparam int SLEEP_ENTRY_DELAY_NS        = 3000;
  localparam int WAKE_DELAY_PLAIN_NS         = 3000;
  localparam int WAKE_DELAY_WITH_IDENT_NS    = 3000;

  // short delays in cycles, least times rounded up
  localparam int SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_PLAIN_CYC   = (WAKE_DELAY_PLAIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_IDENT_CYC   = (WAKE_DELAY_WITH_IDENT_NS * CLK_MHZ + 999) / 1000;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WIPE,
    ST_SLEEP_ENTRY,
    ST_SLEEP,
    ST_WAKE
  } sfid_state_t;

endpackage
